/* rtl/hspc_pkg.sv */
// Purpose: Shared constants and types of the high-speed prescale counter.
// Assumes: Register indexes are the printed offsets; byte address is index times four.
// Notes:   Every number used by more than one file lives here.
package hspc_pkg;

	// Register indexes
	localparam logic [15:0] IDX_T0_CTRL    = 16'hfe10;
	localparam logic [15:0] IDX_T0_CNT_LO  = 16'hfe12;
	localparam logic [15:0] IDX_T0_CNT_HI  = 16'hfe13;
	localparam logic [15:0] IDX_T0_MAT_LO  = 16'hfe14;
	localparam logic [15:0] IDX_T0_MAT_HI  = 16'hfe15;
	localparam logic [15:0] IDX_T0_CAP_LO  = 16'hfe16;
	localparam logic [15:0] IDX_T0_CAP_HI  = 16'hfe17;
	localparam logic [15:0] IDX_P1_TEST    = 16'hfe47;
	localparam logic [15:0] IDX_EINT01     = 16'hfe5d;
	localparam logic [15:0] IDX_EINT23     = 16'hfe5e;
	localparam logic [15:0] IDX_IN_SEL     = 16'hfe5f;
	localparam logic [15:0] IDX_FAST_CTRL  = 16'hfe7d;

	// Bus widths
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;

	// Timer 0 control bit positions
	localparam int T0_HIGH_RUN = 7;
	localparam int T0_LOW_RUN  = 6;
	localparam int T0_WIDE     = 5;
	localparam int T0_EXT_SEL  = 4;
	localparam int T0_HIGH_FLG = 3;
	localparam int T0_HIGH_IE  = 2;
	localparam int T0_LOW_FLG  = 1;
	localparam int T0_LOW_IE   = 0;

	// Port 1 test control: realtime output permit bit
	localparam int P1_RT_PERMIT = 2;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Pre-counter width and synchroniser depth
	localparam int PRE_W  = 3;
	localparam int SYNC_N = 2;

	// Fast counter control register layout
	typedef struct packed {
		logic       en;   // Coupling enable
		logic [2:0] cmp;  // Fine compare field
		logic       cov;  // Captured carry
		logic [2:0] cap;  // Fine capture field
	} hspc_fcc_s;

	localparam hspc_fcc_s FCC_RST = '{en: 1'b0, cmp: 3'h0, cov: 1'b0, cap: 3'h0};

endpackage

/* rtl/hspc_precount.sv */
// Purpose: Small wrap-around pre-counter with overflow strobe.
// Assumes: tick is a one-cycle pulse per counted edge.
// Notes:   ovf is combinational so the next stage counts in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module hspc_precount #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// Control
	input  wire logic             clear,
	input  wire logic             tick,
	// Status
	output logic      [WIDTH-1:0] count,
	output logic      [WIDTH-1:0] count_nxt,
	output logic                  ovf
);

	// Wrap happens when all ones meet a tick
	assign ovf       = tick & (&count);
	assign count_nxt = clear ? '0 : (tick ? count + 1'b1 : count);

	// Counter state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= '0;
		end else begin
			count <= count_nxt;
		end
	end

endmodule
`default_nettype wire

/* rtl/hspc_sync.sv */
// Purpose: Two-stage synchroniser, one bit per lane.
// Assumes: Input may change at any time relative to clk.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/100ps
`default_nettype none
module hspc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// Data
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r;  // First stage, read only by q

	// Plain double flop; the first stage feeds nothing else
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule
`default_nettype wire

/* rtl/hspc_top.sv */
// Purpose: High-speed prescale counter coupled to timer 0, with realtime output.
// Assumes: APB slave on sys_clk; capture strobes and prescale tick come from sys_clk logic.
// Notes:   The count pin is sampled, so edges must be at most one per two sys_clk cycles.
// Behaviour
// - Three-bit pre-counter overflows clock timer 0
// - Coupled timer 0 counts overflows, free-running
// - Output pin switches when extended count hits target
// - Low-byte capture also grabs carry and pre-count
// - Target is (match+1)*8 plus fine compare
// - Enable clear: pin follows port latch
// - Enabled write re-arms, pin holds level
// - After match pin follows latch, no rematch
// - Pre-counter runs with low-byte run control
// - Realtime output needs permit bit set
// - Eight-bit mode 11-bit chain, wide 19-bit
// - Control write with enable set starts new match search
// - Counting starts with enable and external run
// - Capture bits are read-only
// - Pre-counter counts count-pin edges
// - Flag with enable requests its interrupt
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module hspc_top (
	// Clock and reset
	input  wire logic                              sys_clk,
	input  wire logic                              arst_n,
	// APB slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [hspc_pkg::ADDR_W-1:0]       paddr,
	input  wire logic [hspc_pkg::DATA_W-1:0]       pwdata,
	output logic      [hspc_pkg::DATA_W-1:0]       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	// Count pin and timer sources
	input  wire logic                              fast_count_input,
	input  wire logic                              prescale_tick,
	input  wire logic                              capture_low_strobe,
	input  wire logic                              capture_high_strobe,
	// Realtime output pin
	input  wire logic                              port_latch_bit,
	output logic                                   realtime_pin_o,
	// Interrupt requests
	output logic                                   irq_low_o,
	output logic                                   irq_high_o
);

	// Register state
	logic [7:0]          t0_ctrl_r;      // Timer 0 control
	logic [7:0]          t0_lo_r;        // Timer 0 count low
	logic [7:0]          t0_hi_r;        // Timer 0 count high
	logic [7:0]          mat_lo_r;       // Match register low
	logic [7:0]          mat_hi_r;       // Match register high
	logic [7:0]          mbuf_lo_r;      // Match buffer low
	logic [7:0]          mbuf_hi_r;      // Match buffer high
	logic [7:0]          cap_lo_r;       // Capture low
	logic [7:0]          cap_hi_r;       // Capture high
	logic                rt_permit_r;    // Realtime output permit
	logic [7:0]          eint01_r;       // Plain storage
	logic [7:0]          eint23_r;       // Plain storage
	logic [7:0]          in_sel_r;       // Plain storage
	hspc_pkg::hspc_fcc_s fcc_r;          // Fast counter control
	logic                armed_r;        // Match search active
	logic                pin_prev_r;     // Previous synced pin level

	// APB decode
	logic [15:0] idx;
	logic        setup_ph;
	logic        wr_en;
	logic        hit;
	logic [7:0]  wbyte;
	logic [7:0]  rd_mux;

	assign idx      = paddr[hspc_pkg::ADDR_W-1:2];
	assign setup_ph = psel & ~penable;
	assign wr_en    = psel & penable & pready & pwrite;
	assign wbyte    = pwdata[7:0];
	assign hit      = (idx == hspc_pkg::IDX_T0_CTRL)   | (idx == hspc_pkg::IDX_T0_CNT_LO)
	                | (idx == hspc_pkg::IDX_T0_CNT_HI) | (idx == hspc_pkg::IDX_T0_MAT_LO)
	                | (idx == hspc_pkg::IDX_T0_MAT_HI) | (idx == hspc_pkg::IDX_T0_CAP_LO)
	                | (idx == hspc_pkg::IDX_T0_CAP_HI) | (idx == hspc_pkg::IDX_P1_TEST)
	                | (idx == hspc_pkg::IDX_EINT01)    | (idx == hspc_pkg::IDX_EINT23)
	                | (idx == hspc_pkg::IDX_IN_SEL)    | (idx == hspc_pkg::IDX_FAST_CTRL);

	// Per-register write strobes
	logic wr_ctrl;
	logic wr_mlo;
	logic wr_mhi;
	logic wr_p1;
	logic wr_e01;
	logic wr_e23;
	logic wr_isl;
	logic wr_fcc;

	assign wr_ctrl = wr_en & (idx == hspc_pkg::IDX_T0_CTRL);
	assign wr_mlo  = wr_en & (idx == hspc_pkg::IDX_T0_MAT_LO);
	assign wr_mhi  = wr_en & (idx == hspc_pkg::IDX_T0_MAT_HI);
	assign wr_p1   = wr_en & (idx == hspc_pkg::IDX_P1_TEST);
	assign wr_e01  = wr_en & (idx == hspc_pkg::IDX_EINT01);
	assign wr_e23  = wr_en & (idx == hspc_pkg::IDX_EINT23);
	assign wr_isl  = wr_en & (idx == hspc_pkg::IDX_IN_SEL);
	assign wr_fcc  = wr_en & (idx == hspc_pkg::IDX_FAST_CTRL);

	// Read mux; unmapped reads return zero
	assign rd_mux = (idx == hspc_pkg::IDX_T0_CTRL)   ? t0_ctrl_r :
	                (idx == hspc_pkg::IDX_T0_CNT_LO) ? t0_lo_r :
	                (idx == hspc_pkg::IDX_T0_CNT_HI) ? t0_hi_r :
	                (idx == hspc_pkg::IDX_T0_MAT_LO) ? mat_lo_r :
	                (idx == hspc_pkg::IDX_T0_MAT_HI) ? mat_hi_r :
	                (idx == hspc_pkg::IDX_T0_CAP_LO) ? cap_lo_r :
	                (idx == hspc_pkg::IDX_T0_CAP_HI) ? cap_hi_r :
	                (idx == hspc_pkg::IDX_P1_TEST)   ? {5'h00, rt_permit_r, 2'h0} :
	                (idx == hspc_pkg::IDX_EINT01)    ? eint01_r :
	                (idx == hspc_pkg::IDX_EINT23)    ? eint23_r :
	                (idx == hspc_pkg::IDX_IN_SEL)    ? in_sel_r :
	                (idx == hspc_pkg::IDX_FAST_CTRL) ? fcc_r : 8'h00;

	// APB answer: no wait state, data latched in the setup cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~hit;
			prdata  <= setup_ph ? {24'h000000, rd_mux} : '0;
		end
	end

	// Count pin into the sys_clk domain
	logic pin_sync;

	hspc_sync #(
		.WIDTH (1)
	) u_pin_sync (
		.clk    (sys_clk),
		.arst_n (arst_n),
		.d      (fast_count_input),
		.q      (pin_sync)
	);

	// Rising edge of the synced pin
	logic pin_rise;

	assign pin_rise = pin_sync & ~pin_prev_r;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_prev_r <= 1'b0;
		end else begin
			pin_prev_r <= pin_sync;
		end
	end

	// Control field aliases
	logic nk;
	logic wide;
	logic low_run;
	logic high_run;
	logic ext_sel;

	assign nk       = fcc_r.en;
	assign wide     = t0_ctrl_r[hspc_pkg::T0_WIDE];
	assign low_run  = t0_ctrl_r[hspc_pkg::T0_LOW_RUN];
	assign high_run = t0_ctrl_r[hspc_pkg::T0_HIGH_RUN];
	assign ext_sel  = t0_ctrl_r[hspc_pkg::T0_EXT_SEL];

	// Pre-counter runs only when coupled, running and on external clock
	logic                      pre_run;
	logic                      pre_ovf;
	logic [hspc_pkg::PRE_W-1:0] pre_cnt;
	logic [hspc_pkg::PRE_W-1:0] pre_nxt;

	assign pre_run = nk & low_run & ext_sel;

	hspc_precount #(
		.WIDTH (hspc_pkg::PRE_W)
	) u_pre (
		.clk       (sys_clk),
		.arst_n    (arst_n),
		.clear     (~pre_run),
		.tick      (pre_run & pin_rise),
		.count     (pre_cnt),
		.count_nxt (pre_nxt),
		.ovf       (pre_ovf)
	);

	// Timer 0 count sources
	logic l_tick;
	logic h_tick;
	logic l_hit;
	logic h_hit;
	logic w_hit;

	// Coupled low byte counts only pre-counter overflows
	assign l_tick = low_run & (nk ? pre_ovf : (ext_sel ? pin_rise : prescale_tick));
	assign h_tick = high_run & prescale_tick;
	// Low-byte and wide reload-on-match is suppressed while coupled; the 8-bit high byte still reloads
	assign l_hit  = ~nk & (t0_lo_r == mbuf_lo_r);
	assign h_hit  = t0_hi_r == mbuf_hi_r;
	assign w_hit  = ~nk & ({t0_hi_r, t0_lo_r} == {mbuf_hi_r, mbuf_lo_r});

	// Normal match pulses
	logic nm_lo;
	logic nm_hi;

	assign nm_lo = wide ? (l_tick & w_hit) : (l_tick & l_hit);
	assign nm_hi = wide ? (l_tick & w_hit) : (h_tick & h_hit);

	// Timer 0 counting; wide mode chains low into high
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			t0_lo_r <= hspc_pkg::RST_BYTE;
			t0_hi_r <= hspc_pkg::RST_BYTE;
		end else if (wide) begin
			// 19-bit chain when coupled, else 16-bit timer
			if (!low_run) begin
				{t0_hi_r, t0_lo_r} <= 16'h0000;
			end else if (nm_lo) begin
				{t0_hi_r, t0_lo_r} <= 16'h0000;
			end else if (l_tick) begin
				{t0_hi_r, t0_lo_r} <= {t0_hi_r, t0_lo_r} + 16'h0001;
			end
		end else begin
			// Low byte: 11-bit chain when coupled
			if (!low_run) begin
				t0_lo_r <= 8'h00;
			end else if (nm_lo) begin
				t0_lo_r <= 8'h00;
			end else if (l_tick) begin
				t0_lo_r <= t0_lo_r + 8'h01;
			end
			// High byte runs as a normal timer
			if (!high_run) begin
				t0_hi_r <= 8'h00;
			end else if (nm_hi) begin
				t0_hi_r <= 8'h00;
			end else if (h_tick) begin
				t0_hi_r <= t0_hi_r + 8'h01;
			end
		end
	end

	// Match buffers follow the register while stopped, reload on match
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mbuf_lo_r <= hspc_pkg::RST_BYTE;
			mbuf_hi_r <= hspc_pkg::RST_BYTE;
		end else begin
			mbuf_lo_r <= (!low_run || nm_lo) ? mat_lo_r : mbuf_lo_r;
			mbuf_hi_r <= (!high_run || nm_hi) ? mat_hi_r : mbuf_hi_r;
		end
	end

	// Extended count and target; one spare bit absorbs the +1 carry
	logic [19:0] ext_cnt;
	logic [19:0] target;
	logic [8:0]  lo_p1;
	logic [16:0] w_p1;
	logic        x_match;

	assign lo_p1   = {1'b0, mat_lo_r} + 9'h001;
	assign w_p1    = {1'b0, mat_hi_r, mat_lo_r} + 17'h00001;
	assign ext_cnt = wide ? {1'b0, t0_hi_r, t0_lo_r, pre_cnt}
	                      : {9'h000, t0_lo_r, pre_cnt};
	assign target  = wide ? {w_p1, fcc_r.cmp} : {8'h00, lo_p1, fcc_r.cmp};
	// One hit per arming; the search ends on the hit
	assign x_match = armed_r & nk & (ext_cnt == target);

	// Match search arming: any control write with enable set re-arms
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			armed_r <= 1'b0;
		end else if (wr_fcc) begin
			armed_r <= wbyte[7];
		end else if (x_match || !nk) begin
			armed_r <= 1'b0;
		end
	end

	// Realtime pin: hold while armed, take latch value at the hit, then follow latch
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			realtime_pin_o <= 1'b0;
		end else if (!rt_permit_r || !nk) begin
			realtime_pin_o <= port_latch_bit;
		end else if (armed_r && !x_match) begin
			realtime_pin_o <= realtime_pin_o;
		end else begin
			realtime_pin_o <= port_latch_bit;
		end
	end

	// Extended match reaches the flags through two stages
	logic x_match_s;

	hspc_sync #(
		.WIDTH (1)
	) u_match_sync (
		.clk    (sys_clk),
		.arst_n (arst_n),
		.d      (x_match),
		.q      (x_match_s)
	);

	// Flag set sources; wide mode sets both flags together
	logic set_lo;
	logic set_hi;

	assign set_lo = nm_lo | x_match_s;
	assign set_hi = nm_hi | (wide & x_match_s);

	// Timer 0 control; a set in the same cycle beats a software clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			t0_ctrl_r <= hspc_pkg::RST_BYTE;
		end else begin
			if (wr_ctrl) begin
				t0_ctrl_r <= wbyte;
			end
			if (set_lo) begin
				t0_ctrl_r[hspc_pkg::T0_LOW_FLG] <= 1'b1;
			end
			if (set_hi) begin
				t0_ctrl_r[hspc_pkg::T0_HIGH_FLG] <= 1'b1;
			end
		end
	end

	// Match registers and plain storage
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mat_lo_r    <= hspc_pkg::RST_BYTE;
			mat_hi_r    <= hspc_pkg::RST_BYTE;
			rt_permit_r <= 1'b0;
			eint01_r    <= hspc_pkg::RST_BYTE;
			eint23_r    <= hspc_pkg::RST_BYTE;
			in_sel_r    <= hspc_pkg::RST_BYTE;
		end else begin
			mat_lo_r    <= wr_mlo ? wbyte : mat_lo_r;
			mat_hi_r    <= wr_mhi ? wbyte : mat_hi_r;
			rt_permit_r <= wr_p1 ? wbyte[hspc_pkg::P1_RT_PERMIT] : rt_permit_r;
			eint01_r    <= wr_e01 ? wbyte : eint01_r;
			eint23_r    <= wr_e23 ? wbyte : eint23_r;
			in_sel_r    <= wr_isl ? wbyte : in_sel_r;
		end
	end

	// Fast counter control: software owns enable and compare only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fcc_r <= hspc_pkg::FCC_RST;
		end else begin
			if (wr_fcc) begin
				fcc_r.en  <= wbyte[7];
				fcc_r.cmp <= wbyte[6:4];
			end
			if (capture_low_strobe) begin
				// Carry marks an overflow the captured low byte has not seen yet
				fcc_r.cov <= pre_ovf;
				fcc_r.cap <= pre_nxt;
			end
		end
	end

	// Timer 0 capture registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_lo_r <= hspc_pkg::RST_BYTE;
			cap_hi_r <= hspc_pkg::RST_BYTE;
		end else begin
			cap_lo_r <= capture_low_strobe ? t0_lo_r : cap_lo_r;
			cap_hi_r <= capture_high_strobe ? t0_hi_r : cap_hi_r;
		end
	end

	// Interrupt requests: flag and enable together
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_low_o  <= 1'b0;
			irq_high_o <= 1'b0;
		end else begin
			irq_low_o  <= t0_ctrl_r[hspc_pkg::T0_LOW_FLG] & t0_ctrl_r[hspc_pkg::T0_LOW_IE];
			irq_high_o <= t0_ctrl_r[hspc_pkg::T0_HIGH_FLG] & t0_ctrl_r[hspc_pkg::T0_HIGH_IE];
		end
	end

endmodule
`default_nettype wire

/* verif/hspc_pulse_src.sv */
// Purpose: Pulse source on the count pin.
// Assumes: Levels last over two sys_clk cycles.
// Notes:   Free-running timing; idles low.
`timescale 1ns/100ps
`default_nettype none
module hspc_pulse_src (
	// Burst request
	input  wire logic        go,
	input  wire logic        slow,
	input  wire logic [15:0] n,
	// Pin and status
	output logic             fast_count_input,
	output logic             busy
);
	// Idle low from time zero
	initial begin
		fast_count_input = 1'b0;
		busy = 1'b0;
	end

	// One burst per go; slow stretches levels to test a lazy source
	always @(posedge go) begin
		busy = 1'b1;
		repeat (n) begin
			#(slow ? 370 : 130) fast_count_input = 1'b1;
			#(slow ? 370 : 130) fast_count_input = 1'b0;
		end
		busy = 1'b0;
	end
endmodule
`default_nettype wire

/* verif/hspc_top_asserts.sv */
// Purpose: Port-level checks.
// Assumes: Control bits rebuilt from APB writes.
// Notes:   Sees only hspc_top ports.
`timescale 1ns/100ps
`default_nettype none
module hspc_top_chk (
	// Clock and reset
	input wire logic                        sys_clk,
	input wire logic                        arst_n,
	// APB
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [hspc_pkg::ADDR_W-1:0] paddr,
	input wire logic [hspc_pkg::DATA_W-1:0] pwdata,
	input wire logic [hspc_pkg::DATA_W-1:0] prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	// Pins and strobes
	input wire logic                        fast_count_input,
	input wire logic                        prescale_tick,
	input wire logic                        capture_low_strobe,
	input wire logic                        capture_high_strobe,
	input wire logic                        port_latch_bit,
	input wire logic                        realtime_pin_o,
	input wire logic                        irq_low_o,
	input wire logic                        irq_high_o
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Decoded index and completed write
	wire logic [15:0] idx;
	wire logic        wr;
	assign idx = paddr[hspc_pkg::ADDR_W-1:2];
	assign wr  = psel & penable & pready & pwrite;

	// Shadow bits: enable, permit, high ie, low ie
	logic [3:0] sh_r;
	logic [3:0] sh_nxt;
	assign sh_nxt[3] = (wr && idx == hspc_pkg::IDX_FAST_CTRL) ? pwdata[7] : sh_r[3];
	assign sh_nxt[2] = (wr && idx == hspc_pkg::IDX_P1_TEST) ? pwdata[2] : sh_r[2];
	assign sh_nxt[1] = (wr && idx == hspc_pkg::IDX_T0_CTRL) ? pwdata[2] : sh_r[1];
	assign sh_nxt[0] = (wr && idx == hspc_pkg::IDX_T0_CTRL) ? pwdata[0] : sh_r[0];

	// Cleared with the design
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sh_r <= 4'h0;
		end else begin
			sh_r <= sh_nxt;
		end
	end

	property p_rdy; psel && !penable |=> pready && penable; endproperty
	a_rdy: assert property (p_rdy) else $error("pready missing in access cycle");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("pready held over one cycle");
	// Only the fexx page is mapped
	property p_err; psel && !penable && idx[15:8] != 8'hfe |=> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read data not zero");
	property p_follow; !sh_r[3] || !sh_r[2] |=> realtime_pin_o == $past(port_latch_bit); endproperty
	a_follow: assert property (p_follow) else $error("pin not following latch");
	property p_chg; $changed(realtime_pin_o) |-> realtime_pin_o == $past(port_latch_bit); endproperty
	a_chg: assert property (p_chg) else $error("pin took a level not from latch");
	// Arming edge still follows old state
	property p_hold;
		wr && idx == hspc_pkg::IDX_FAST_CTRL && pwdata[7] && sh_r[2]
			|=> ##1 $stable(realtime_pin_o)[*2];
	endproperty
	a_hold: assert property (p_hold) else $error("armed pin did not hold");
	property p_irq_lo; irq_low_o |-> $past(sh_r[0]); endproperty
	a_irq_lo: assert property (p_irq_lo) else $error("low irq without enable");
	property p_irq_hi; irq_high_o |-> $past(sh_r[1]); endproperty
	a_irq_hi: assert property (p_irq_hi) else $error("high irq without enable");

	// Main scenarios reached
	cover property (wr && idx == hspc_pkg::IDX_FAST_CTRL && pwdata[7]);
	cover property ($rose(irq_low_o));
	cover property ($rose(pslverr));
endmodule

bind hspc_top hspc_top_chk u_hspc_top_chk (.*);
`default_nettype wire

/* verif/tb_high_speed_prescale_counter.sv */
// Purpose: Self-checking bench, high-speed prescale counter.
// Assumes: APB slave answers; pin pulses from the partner model.
// Notes:   Seeded random values.
`timescale 1ns/100ps
`default_nettype none
module tb_high_speed_prescale_counter;
	// Driven inputs
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0;
	logic        tick = 1'b0;
	logic        cap_lo = 1'b0;
	logic        cap_hi = 1'b0;
	logic        latch = 1'b0;
	logic        go = 1'b0;
	logic        slow = 1'b0;
	logic [15:0] n = 16'h0;
	// Observed
	logic [31:0] prdata;
	logic        pready, pslverr, pin, irq_lo, irq_hi, fci, busy;
	// Bench state
	int          fail_count = 0;
	int          check_count = 0;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  v;
	int          m, c, p;
	// Register indexes
	logic [15:0] p_regs [11] = '{hspc_pkg::IDX_T0_CTRL, hspc_pkg::IDX_T0_CNT_LO,
		hspc_pkg::IDX_T0_CNT_HI, hspc_pkg::IDX_T0_MAT_LO, hspc_pkg::IDX_T0_MAT_HI,
		hspc_pkg::IDX_T0_CAP_LO, hspc_pkg::IDX_T0_CAP_HI, hspc_pkg::IDX_P1_TEST,
		hspc_pkg::IDX_EINT01, hspc_pkg::IDX_EINT23, hspc_pkg::IDX_IN_SEL};

	always #25 sys_clk = ~sys_clk;

	hspc_top u_hspc_top (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fast_count_input(fci),
		.prescale_tick(tick), .capture_low_strobe(cap_lo), .capture_high_strobe(cap_hi),
		.port_latch_bit(latch), .realtime_pin_o(pin), .irq_low_o(irq_lo),
		.irq_high_o(irq_hi));
	hspc_pulse_src u_hspc_pulse_src (.go(go), .slow(slow), .n(n),
		.fast_count_input(fci), .busy(busy));

	// Expected values
	function automatic logic [31:0] lo_exp(int p);
		return 32'((p / 8) % 256);
	endfunction
	function automatic int target(int m, int c);
		return (m + 1) * 8 + c;
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic [15:0] idx, input logic w, input logic [7:0] d);
		int k = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && k < 16) begin
			@(posedge sys_clk);
			k++;
		end
		if (k == 16) fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Pin burst, then sync and flag latency
	task automatic pulses(input int cnt, input logic s);
		n <= 16'(cnt);
		slow <= s;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (30000) if (busy) @(posedge sys_clk);
		repeat (8) @(posedge sys_clk);
	endtask

	// Pin copies latch one edge later
	task automatic follow;
		repeat (8) begin
			@(posedge sys_clk);
			v = 8'($urandom);
			latch <= v[0];
			@(posedge sys_clk);
			#1 chk("pin", {31'h0, v[0]}, {31'h0, pin});
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard, well above the longest burst
	initial begin
		repeat (60000) @(posedge sys_clk);
		fail_count++;
		wrap_up();
	end

	initial begin
		v = 8'($urandom(5));
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		// Every register except fast counter control zero after reset
		foreach (p_regs[i]) begin
			apb(p_regs[i], 1'b0, 8'h0);
			chk("reset", 32'h0, rd);
		end
		apb(16'h0000, 1'b1, 8'hff);
		chk("err", 32'h1, {31'h0, err});
		apb(16'h0000, 1'b0, 8'h0);
		chk("unmapped", 32'h0, rd);
		// Storage and read-only
		foreach (p_regs[i]) begin
			v = 8'($urandom);
			apb(p_regs[i], 1'b1, v);
			apb(p_regs[i], 1'b0, 8'h0);
			if (i inside {1, 2, 5, 6}) chk("ro", 32'h0, rd);
			else if (i inside {3, 4, 8, 9, 10}) chk("rw", {24'h0, v}, rd);
		end
		apb(hspc_pkg::IDX_P1_TEST, 1'b1, 8'hff);
		apb(hspc_pkg::IDX_P1_TEST, 1'b0, 8'h0);
		chk("permit", 32'h4, rd);
		apb(hspc_pkg::IDX_FAST_CTRL, 1'b1, 8'hff);
		apb(hspc_pkg::IDX_FAST_CTRL, 1'b0, 8'h0);
		chk("cap ro", 32'hf0, rd);
		apb(hspc_pkg::IDX_T0_CTRL, 1'b1, 8'h0c);
		repeat (2) @(posedge sys_clk);
		#1 chk("irq hi", 32'h1, {31'h0, irq_hi});
		apb(hspc_pkg::IDX_T0_CTRL, 1'b1, 8'h00);
		apb(hspc_pkg::IDX_FAST_CTRL, 1'b1, 8'h00);
		$display("test registers done");
		// Follow latch: enable off, then permit off
		follow();
		apb(hspc_pkg::IDX_FAST_CTRL, 1'b1, 8'h80);
		apb(hspc_pkg::IDX_P1_TEST, 1'b1, 8'h00);
		follow();
		$display("test follow done");
		// Run off: pin edges must not count
		apb(hspc_pkg::IDX_T0_CTRL, 1'b1, 8'h10);
		pulses(10, 1'b0);
		apb(hspc_pkg::IDX_T0_CNT_LO, 1'b0, 8'h0);
		chk("stopped", 32'h0, rd);
		// Coupled 8-bit chain must not reload
		apb(hspc_pkg::IDX_T0_MAT_LO, 1'b1, 8'h01);
		apb(hspc_pkg::IDX_T0_MAT_HI, 1'b1, 8'hff);
		apb(hspc_pkg::IDX_T0_CTRL, 1'b1, 8'hd0);
		p = 16 + $urandom_range(40);
		pulses(p, 1'b0);
		apb(hspc_pkg::IDX_T0_CNT_LO, 1'b0, 8'h0);
		chk("chain lo", lo_exp(p), rd);
		@(posedge sys_clk);
		cap_lo <= 1'b1;
		cap_hi <= 1'b1;
		@(posedge sys_clk);
		cap_lo <= 1'b0;
		cap_hi <= 1'b0;
		apb(hspc_pkg::IDX_FAST_CTRL, 1'b0, 8'h0);
		chk("fine cap", 32'(8'h80 | (p % 8)), rd);
		apb(hspc_pkg::IDX_T0_CAP_LO, 1'b0, 8'h0);
		chk("cap lo", lo_exp(p), rd);
		// High byte runs alone on the prescale tick
		repeat (3) begin
			@(posedge sys_clk);
			tick <= 1'b1;
			@(posedge sys_clk);
			tick <= 1'b0;
		end
		apb(hspc_pkg::IDX_T0_CNT_HI, 1'b0, 8'h0);
		chk("normal hi", 32'h3, rd);
		$display("test chain8 done");
		// Wide 19-bit chain
		apb(hspc_pkg::IDX_T0_CTRL, 1'b1, 8'h00);
		apb(hspc_pkg::IDX_T0_CTRL, 1'b1, 8'hf0);
		p = 2048 + 8 * $urandom_range(7, 1);
		pulses(p, 1'b0);
		apb(hspc_pkg::IDX_T0_CNT_HI, 1'b0, 8'h0);
		chk("wide hi", 32'h1, rd);
		apb(hspc_pkg::IDX_T0_CNT_LO, 1'b0, 8'h0);
		chk("wide lo", lo_exp(p), rd);
		$display("test chain16 done");
		// Match: arm, hold, fire, release, no rematch
		apb(hspc_pkg::IDX_T0_CTRL, 1'b1, 8'h00);
		apb(hspc_pkg::IDX_FAST_CTRL, 1'b1, 8'h00);
		apb(hspc_pkg::IDX_P1_TEST, 1'b1, 8'h04);
		m = $urandom_range(3, 1);
		c = $urandom_range(7);
		apb(hspc_pkg::IDX_T0_MAT_LO, 1'b1, 8'(m));
		apb(hspc_pkg::IDX_T0_CTRL, 1'b1, 8'h51);
		apb(hspc_pkg::IDX_FAST_CTRL, 1'b1, {1'b1, 3'(c), 4'h0});
		latch <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("hold", 32'h0, {31'h0, pin});
		pulses(target(m, c) - 1, 1'b1);
		chk("early", 32'h0, {30'h0, irq_lo, pin});
		pulses(1, 1'b0);
		chk("hit", 32'h3, {30'h0, irq_lo, pin});
		apb(hspc_pkg::IDX_T0_CTRL, 1'b0, 8'h0);
		chk("flag", 32'h53, rd);
		apb(hspc_pkg::IDX_T0_CTRL, 1'b1, 8'h52);
		repeat (2) @(posedge sys_clk);
		#1 chk("masked", 32'h0, {31'h0, irq_lo});
		apb(hspc_pkg::IDX_T0_CTRL, 1'b1, 8'h51);
		latch <= 1'b0;
		pulses(8, 1'b0);
		chk("released", 32'h0, {30'h0, irq_lo, pin});
		apb(hspc_pkg::IDX_T0_CTRL, 1'b0, 8'h0);
		chk("no rematch", 32'h51, rd);
		$display("test match done");
		wrap_up();
	end
endmodule
`default_nettype wire
